/* File: ctp_pkg.sv */
// package: register map, field positions and constants of the control timer
package ctp_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int NCH = 4;
  localparam logic [3:0] OFF_CTRLA = 4'h0;
  localparam logic [3:0] OFF_CTRLBCLR = 4'h1;
  localparam logic [3:0] OFF_CTRLBSET = 4'h2;
  localparam logic [3:0] OFF_WAVE = 4'h3;
  localparam logic [3:0] OFF_DRVCTRL = 4'h4;
  localparam logic [3:0] OFF_DBG_CTL = 4'h5;
  localparam logic [3:0] OFF_TOP = 4'h6;
  localparam logic [3:0] OFF_COUNT = 4'h7;
  localparam logic [3:0] OFF_INTFLAG = 4'h8;
  localparam logic [3:0] OFF_INTMASK = 4'h9;
  localparam logic [3:0] OFF_STATUS = 4'hA;
  localparam logic [3:0] OFF_EVCTRL = 4'hB;
  localparam int CA_SWRST = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_PSC_LO = 8;
  localparam int CA_SYNC_LO = 12;
  localparam int CB_DIR = 0;
  localparam int WV_GEN_LO = 0;
  localparam int WV_POL_LO = 8;
  localparam int DRV_INV_LO = 16;
  localparam int EV_CNT = 0;
  localparam int IF_OVF = 0;
  localparam int PSC_W = 3;
  localparam int SYNC_W = 2;
  localparam int PDIV_W = 10;
  localparam logic [2:0] GEN_NFRQ = 3'h0;
  localparam logic [2:0] GEN_NPWM = 3'h2;
  localparam logic [CNT_W-1:0] TOP_RST = 16'hFFFF;
  localparam logic [1:0] SYNC_GCLK = 2'h0;
  localparam logic [1:0] SYNC_PRESC = 2'h1;
  localparam logic [1:0] SYNC_RESYNC = 2'h2;
endpackage : ctp_pkg

/* File: ctp_timer.sv */
// control timer core: registers, prescaler, counter and waveform outputs
`timescale 1ns/1ps
// Contract
// RL1: software sets direction bit for down counting
// RL2: software selects waveform generation mode
// RL3: software selects waveform output polarity
// RL4: per-channel invert enables flip waveform outputs
// RL5: enable bit written one enables, zero disables
// RL6: soft reset clears all but debug control
// RL7: software disables timer before soft reset
// RL8: prescaler counter counts to value, output toggles
// RL9: sync select: update on gclk or prescaled
// RL10: prescale ratios undivided up to 1/1024
// RL11: event counting bypasses prescaler, ticks merge
// RL12: direction zero counts up, one counts down
// RL13: wrap at TOP or ZERO sets overflow flag
// RL14: disabled prescaler holds zero, no ticks
module ctp_timer (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic [3:0] reg_addr, // register index
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic count_event, // one-cycle counting event
  output logic [31:0] reg_rdata_q, // read data, cycle after strobe
  output logic irq_q, // level interrupt
  output logic [3:0] wave_out_q, // waveform outputs
  output logic count_tick_q // count tick, for observation
);
  logic enable_q, dir_q, evcnt_q, dbg_q, ovf_q, ovf_mask_q;
  logic [2:0] psc_q, gen_q;
  logic [1:0] sync_q;
  logic [3:0] pol_q, inv_q;
  logic [15:0] top_q, cnt_q;
  logic [9:0] pdiv_q;
  logic pout_q;
  logic wr_ca, swrst, pre_hit, psc_tick, tick, wrap, ovf_set;
  logic [9:0] pre_lim;
  logic [3:0] wave_d;

  assign wr_ca = reg_wr && reg_addr == ctp_pkg::OFF_CTRLA;
  assign swrst = wr_ca && reg_wdata[ctp_pkg::CA_SWRST]; // RL6

  // division ratio per select code: 1,2,4,8,16,64,256,1024
  always_comb
  begin
    case (psc_q)
      3'h0: pre_lim = 10'h000;
      3'h1: pre_lim = 10'h001;
      3'h2: pre_lim = 10'h003;
      3'h3: pre_lim = 10'h007;
      3'h4: pre_lim = 10'h00F;
      3'h5: pre_lim = 10'h03F;
      3'h6: pre_lim = 10'h0FF;
      default: pre_lim = 10'h3FF;
    endcase
  end

  // at or above the limit, so a ratio change while running cannot skip
  // the hit and run the divider round its full range
  assign pre_hit = pdiv_q >= pre_lim; // RL10
  assign psc_tick = enable_q && !evcnt_q && pre_hit; // RL8 RL14
  assign tick = enable_q && (evcnt_q ? count_event : psc_tick); // RL11
  assign wrap = dir_q ? (cnt_q == 16'h0000) : (cnt_q >= top_q); // RL13
  assign ovf_set = tick && wrap;

  // prescaler divider; held at zero while disabled for a known phase
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pdiv_q <= 10'h000;
      pout_q <= 1'b0;
    end
    else if (!enable_q || evcnt_q || swrst)
    begin
      pdiv_q <= 10'h000; // RL14
      pout_q <= 1'b0;
    end
    else if (pre_hit)
    begin
      pdiv_q <= 10'h000; // RL8
      pout_q <= ~pout_q; // RL8
    end
    else
      pdiv_q <= pdiv_q + 10'h001;
  end

  // control registers; soft reset spares only debug control
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable_q <= 1'b0;
      psc_q <= 3'h0;
      sync_q <= 2'h0;
      dir_q <= 1'b0;
      gen_q <= 3'h0;
      pol_q <= 4'h0;
      inv_q <= 4'h0;
      top_q <= ctp_pkg::TOP_RST;
      evcnt_q <= 1'b0;
      ovf_mask_q <= 1'b0;
      dbg_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == ctp_pkg::OFF_DBG_CTL)
        dbg_q <= reg_wdata[0];
      if (swrst)
      begin
        enable_q <= 1'b0; // RL6
        psc_q <= 3'h0;
        sync_q <= 2'h0;
        dir_q <= 1'b0;
        gen_q <= 3'h0;
        pol_q <= 4'h0;
        inv_q <= 4'h0;
        top_q <= ctp_pkg::TOP_RST;
        evcnt_q <= 1'b0;
        ovf_mask_q <= 1'b0;
      end
      else if (reg_wr)
      begin
        case (reg_addr)
          ctp_pkg::OFF_CTRLA:
          begin
            enable_q <= reg_wdata[ctp_pkg::CA_ENABLE]; // RL5
            psc_q <= reg_wdata[ctp_pkg::CA_PSC_LO +: ctp_pkg::PSC_W];
            sync_q <= reg_wdata[ctp_pkg::CA_SYNC_LO +: ctp_pkg::SYNC_W];
          end
          ctp_pkg::OFF_CTRLBSET:
            if (reg_wdata[ctp_pkg::CB_DIR]) dir_q <= 1'b1;
          ctp_pkg::OFF_CTRLBCLR:
            if (reg_wdata[ctp_pkg::CB_DIR]) dir_q <= 1'b0;
          ctp_pkg::OFF_WAVE:
          begin
            gen_q <= reg_wdata[ctp_pkg::WV_GEN_LO +: 3];
            pol_q <= reg_wdata[ctp_pkg::WV_POL_LO +: ctp_pkg::NCH];
          end
          ctp_pkg::OFF_DRVCTRL:
            inv_q <= reg_wdata[ctp_pkg::DRV_INV_LO +: ctp_pkg::NCH];
          ctp_pkg::OFF_TOP: top_q <= reg_wdata[15:0];
          ctp_pkg::OFF_EVCTRL: evcnt_q <= reg_wdata[ctp_pkg::EV_CNT];
          ctp_pkg::OFF_INTMASK: ovf_mask_q <= reg_wdata[ctp_pkg::IF_OVF];
          default: ;
        endcase
      end
    end
  end

  // counter; a direct write beats counting, wrap reloads per direction
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= 16'h0000;
    else if (swrst)
      cnt_q <= 16'h0000;
    else if (reg_wr && reg_addr == ctp_pkg::OFF_COUNT)
      cnt_q <= reg_wdata[15:0];
    else if (tick)
    begin
      if (wrap)
        cnt_q <= dir_q ? top_q : 16'h0000; // RL13
      else if (dir_q)
        cnt_q <= cnt_q - 16'h0001; // RL12
      else
        cnt_q <= cnt_q + 16'h0001; // RL12
    end
  end

  // overflow flag: soft reset first, then set wins over a write-one clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ovf_q <= 1'b0;
    else if (swrst)
      ovf_q <= 1'b0; // RL6
    else if (ovf_set)
      ovf_q <= 1'b1; // RL13
    else if (reg_wr && reg_addr == ctp_pkg::OFF_INTFLAG &&
             reg_wdata[ctp_pkg::IF_OVF])
      ovf_q <= 1'b0;
  end

  // normal pwm: high below compare-at-half-top; frequency mode: toggle
  generate
    for (genvar i = 0; i < ctp_pkg::NCH; i++)
    begin : g_ch
      always_comb
      begin
        if (gen_q == ctp_pkg::GEN_NPWM)
          wave_d[i] = (cnt_q < (top_q >> 1)) ^ pol_q[i]; // RL3
        else
          wave_d[i] = pout_q ^ pol_q[i];
        wave_d[i] = wave_d[i] ^ inv_q[i]; // RL4
      end
    end
  endgenerate

  // outputs registered; gclk sync updates every clock, prescaled sync
  // holds the waveform between count ticks, except when psc_q is zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wave_out_q <= 4'h0;
      count_tick_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      count_tick_q <= tick;
      irq_q <= (ovf_q || ovf_set) && ovf_mask_q;
      if (sync_q == ctp_pkg::SYNC_GCLK || psc_q == 3'h0 || tick)
        wave_out_q <= wave_d; // RL9
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_q <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata_q <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        ctp_pkg::OFF_CTRLA:
          reg_rdata_q <= {18'h0, sync_q, 1'b0, psc_q, 6'h0, enable_q, 1'b0};
        ctp_pkg::OFF_CTRLBSET, ctp_pkg::OFF_CTRLBCLR:
          reg_rdata_q <= {31'h0, dir_q};
        ctp_pkg::OFF_WAVE:
          reg_rdata_q <= {20'h0, pol_q, 5'h0, gen_q};
        ctp_pkg::OFF_DRVCTRL: reg_rdata_q <= {12'h0, inv_q, 16'h0};
        ctp_pkg::OFF_DBG_CTL: reg_rdata_q <= {31'h0, dbg_q};
        ctp_pkg::OFF_TOP: reg_rdata_q <= {16'h0, top_q};
        ctp_pkg::OFF_COUNT: reg_rdata_q <= {16'h0, cnt_q};
        ctp_pkg::OFF_INTFLAG: reg_rdata_q <= {31'h0, ovf_q};
        ctp_pkg::OFF_INTMASK: reg_rdata_q <= {31'h0, ovf_mask_q};
        ctp_pkg::OFF_STATUS:
          reg_rdata_q <= {30'h0, pout_q, enable_q};
        ctp_pkg::OFF_EVCTRL: reg_rdata_q <= {31'h0, evcnt_q};
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end
  end
endmodule : ctp_timer

/* File: ctp_timer_sva.sv */
// port assertions for the control timer
`timescale 1ns/1ps
module ctp_timer_sva (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // reset, low
  input wire logic [3:0] reg_addr, // index
  input wire logic [31:0] reg_wdata, // data
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic count_event, // event
  input wire logic [31:0] reg_rdata_q, // rdata
  input wire logic irq_q, // irq
  input wire logic [3:0] wave_out_q, // waves
  input wire logic count_tick_q // tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic en_s, ev_s, mk_s, ca_wr, c2;
  logic [2:0] ps_s;
  assign ca_wr = reg_wr && reg_addr == 4'h0;
  assign c2 = en_s && !ev_s && ps_s == 3'h1;
  // shadow of the setup so tick spacing can be tied to the written ratio
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      {en_s, ev_s, mk_s, ps_s} <= '0;
    else if (ca_wr && reg_wdata[0])
      {en_s, ev_s, mk_s, ps_s} <= '0;
    else if (ca_wr)
      {en_s, ps_s} <= {reg_wdata[1], reg_wdata[10:8]};
    else if (reg_wr && reg_addr == 4'hB)
      ev_s <= reg_wdata[0];
    else if (reg_wr && reg_addr == 4'h9)
      mk_s <= reg_wdata[0];
  end
  rd_one_cycle_a:
    assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data outside its cycle");
  off_no_tick_a:
    assert property (ca_wr && !reg_wdata[1] |=> ##1 !count_tick_q [*3])
    else $error("tick while disabled");
  swrst_quiet_a:
    assert property (ca_wr && reg_wdata[0] |=> ##1 !irq_q [*3])
    else $error("irq after soft reset");
  div_one_a:
    assert property ((en_s && !ev_s && ps_s == 3'h0) [*3] |-> count_tick_q)
    else $error("undivided tick missing");
  div_two_a:
    assert property ((c2 && count_tick_q) ##1 c2 ##1 c2
      |-> count_tick_q && !$past(count_tick_q))
    else $error("divide by two spacing wrong");
  evt_tick_a:
    assert property ((en_s && ev_s) [*2] |-> count_tick_q == $past(count_event))
    else $error("event tick wrong");
  irq_wrap_a:
    assert property ($rose(irq_q) && $past(mk_s, 2) |-> count_tick_q)
    else $error("irq rose without a wrap");
  irq_masked_a:
    assert property (!mk_s |=> !irq_q)
    else $error("irq while masked");
  c_evt: cover property (en_s && ev_s && count_tick_q);
  c_irq: cover property ($rose(irq_q));
  c_swrst: cover property (ca_wr && reg_wdata[0]);
endmodule : ctp_timer_sva
bind ctp_timer ctp_timer_sva i_ctp_timer_sva (.sys_clk(sys_clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .count_event(count_event),
  .reg_rdata_q(reg_rdata_q), .irq_q(irq_q), .wave_out_q(wave_out_q),
  .count_tick_q(count_tick_q));

/* File: ctp_timer_test.sv */
// self-checking bench for the control timer
`timescale 1ns/1ps
module ctp_timer_test;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic count_event = 1'b0, irq_q, count_tick_q;
  logic [3:0] reg_addr = 4'h0, wave_out_q;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q, rv;
  int err_count = 0, n_checks = 0, cyc = 0;
  int rat [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  always #2 sys_clk = ~sys_clk;
  ctp_timer i_ctp_timer (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .count_event(count_event), .reg_rdata_q(reg_rdata_q),
    .irq_q(irq_q), .wave_out_q(wave_out_q), .count_tick_q(count_tick_q));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(string w, logic [3:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(w, e, reg_rdata_q);
  endtask : rdc
  // enable for k idle cycles; the prescaler restarts on every enable
  task automatic run(int p, int k);
    wr(4'h0, 32'h2 | (p << 8));
    repeat (k) @(posedge sys_clk);
    wr(4'h0, p << 8);
  endtask : run
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc("top", 4'h6, 32'hFFFF);
    rdc("unmapped", 4'hC, 32'h0);
    wr(4'h3, 32'h302);
    wr(4'h4, 32'h50000);
    repeat (2) @(posedge sys_clk);
    #1 chk("wave", 32'h9, {28'h0, wave_out_q});
    $display("setup test done");
    wr(4'h9, 32'h1);
    wr(4'h7, 32'hFFFE);
    run(0, 1);
    rdc("count up", 4'h7, 32'h1);
    rdc("flag", 4'h8, 32'h1);
    chk("irq", 32'h1, {31'h0, irq_q});
    wr(4'h8, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq clr", 32'h0, {31'h0, irq_q});
    wr(4'h2, 32'h1);
    run(0, 1);
    rdc("count down", 4'h7, 32'hFFFE);
    rdc("flag", 4'h8, 32'h1);
    wr(4'h1, 32'h1);
    rdc("dir", 4'h2, 32'h0);
    $display("wrap test done");
    for (int p = 0; p < 8; p++)
    begin
      wr(4'h7, 32'h0);
      run(p, 2 * rat[p] + 1);
      rdc("ratio", 4'h7, (2 * rat[p] + 3) / rat[p]);
    end
    $display("prescale test done");
    wr(4'h3, 32'h2);
    wr(4'h4, 32'h0);
    wr(4'h6, 32'h4);
    wr(4'h7, 32'h0);
    wr(4'h0, 32'h1702);
    wr(4'h7, 32'h3);
    rdc("status", 4'hA, 32'h1);
    #1 chk("wave held", 32'hF, {28'h0, wave_out_q});
    wr(4'h0, 32'h0702);
    repeat (2) @(posedge sys_clk);
    #1 chk("wave free", 32'h0, {28'h0, wave_out_q});
    wr(4'h0, 32'h0);
    $display("sync test done");
    wr(4'hB, 32'h1);
    wr(4'h7, 32'h0);
    wr(4'h0, 32'h702);
    repeat (3)
    begin
      @(posedge sys_clk) count_event <= 1'b1;
      @(posedge sys_clk) count_event <= 1'b0;
      #1 chk("tick", 32'h1, {31'h0, count_tick_q});
    end
    wr(4'h0, 32'h0);
    rdc("events", 4'h7, 32'h3);
    wr(4'h5, 32'h1);
    wr(4'h6, 32'h9);
    wr(4'h0, 32'h1);
    rdc("top rst", 4'h6, 32'hFFFF);
    rdc("dbg kept", 4'h5, 32'h1);
    rdc("ev rst", 4'hB, 32'h0);
    chk("wave rst", 32'h0, {28'h0, wave_out_q});
    $display("event and reset test done");
    summarize();
  end
endmodule : ctp_timer_test
